/* File: design/spc_pkg.sv */
`default_nettype none
package spc_pkg;
    // register indexes, byte address is four times the index
    localparam logic [11:0] FIRST_PORT_BASE_IDX  = 12'h000;
    localparam logic [11:0] SECOND_PORT_BASE_IDX = 12'h100;
    localparam logic [11:0] MODE_IDX             = 12'h0f0;
    localparam logic [11:0] IR_OPTION_IDX        = 12'h0f1;
    localparam logic [11:0] IR_TIMEOUT_IDX       = 12'h0f2;
    localparam logic [11:0] INT_STATUS_IDX       = 12'h200;
    localparam logic [11:0] INT_MASK_IDX         = 12'h201;
    localparam logic [11:0] LINK_STATE_IDX       = 12'h202;

    // field positions
    localparam int SHARE_IRQ_BIT   = 7;
    localparam int MUSIC_LINK_BIT  = 0;
    localparam int HIGH_SPEED_BIT  = 1;
    localparam int RX_POL_BIT      = 0;
    localparam int TX_POL_BIT      = 1;
    localparam int DUPLEX_BIT      = 2;
    localparam int IR_MODE_LSB     = 3;
    localparam int IR_MODE_MSB     = 5;

    // writable bits, reserved bits read zero
    localparam logic [7:0] FIRST_MODE_WMASK  = 8'h81;
    localparam logic [7:0] SECOND_MODE_WMASK = 8'h03;
    localparam logic [7:0] IR_OPTION_WMASK   = 8'h3f;
    localparam logic [3:0] INT_WMASK         = 4'hf;

    // reset values
    localparam logic [7:0] FIRST_MODE_RESET  = 8'h00;
    localparam logic [7:0] SECOND_MODE_RESET = 8'h00;
    localparam logic [7:0] IR_OPTION_RESET   = 8'h02;
    localparam logic [7:0] IR_TIMEOUT_RESET  = 8'h03;
    localparam logic [3:0] INT_MASK_RESET    = 4'h0;

    // interrupt status bit positions
    localparam int EV_FIRST_IRQ  = 0;
    localparam int EV_SECOND_IRQ = 1;
    localparam int EV_BLANK_END  = 2;
    localparam int EV_RX_DROP    = 3;

    // timing
    localparam int CLOCK_MHZ        = 200;
    localparam int BLANK_STEP_NS    = 100_000;
    localparam int BLANK_MAX_NS     = 10_000_000;
    localparam int BLANK_STEP_CYCLES = BLANK_STEP_NS * CLOCK_MHZ / 1000;
    localparam logic [7:0] BLANK_MAX_STEPS = 8'(BLANK_MAX_NS / BLANK_STEP_NS);

    typedef enum logic [2:0] {
        IR_MODE_STANDARD = 3'h0,
        IR_MODE_IRDA     = 3'h1,
        IR_MODE_ASK      = 3'h2
    } spc_ir_mode_t;
endpackage
`default_nettype wire

/* File: design/spc_blank_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module spc_blank_timer
    import spc_pkg::*;
#(
    parameter logic [15:0] STEP_CYCLES = 16'(spc_pkg::BLANK_STEP_CYCLES)
)
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       active,
    input  wire logic [7:0] steps,
    output logic            blanking,
    output logic            blankEnd
);
    logic [15:0] preCnt_reg;
    logic [15:0] preCnt_next;
    logic [7:0]  stepCnt_reg;
    logic [7:0]  stepCnt_next;
    logic        tick;

    // prescaler restarts with each activity so every step is a full 100 us
    always_comb
    begin
        tick = (preCnt_reg == STEP_CYCLES - 16'h0001);
        preCnt_next = preCnt_reg;
        stepCnt_next = stepCnt_reg;
        if (active)
        begin
            preCnt_next = 16'h0000;
            stepCnt_next = (steps > BLANK_MAX_STEPS) ? BLANK_MAX_STEPS : steps;
        end
        else if (stepCnt_reg != 8'h00)
        begin
            preCnt_next = tick ? 16'h0000 : preCnt_reg + 16'h0001;
            if (tick)
            begin
                stepCnt_next = stepCnt_reg - 8'h01;
            end
        end
        blanking = active || (stepCnt_reg != 8'h00);
        blankEnd = !active && tick && (stepCnt_reg == 8'h01);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            preCnt_reg <= 16'h0000;
            stepCnt_reg <= 8'h00;
        end
        else
        begin
            preCnt_reg <= preCnt_next;
            stepCnt_reg <= stepCnt_next;
        end
    end
endmodule // spc_blank_timer
`default_nettype wire

/* File: design/spc_serial_cfg.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module spc_serial_cfg
    import spc_pkg::*;
#(
    parameter logic [15:0] STEP_CYCLES = 16'(spc_pkg::BLANK_STEP_CYCLES)
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        firstIrqReq,
    input  wire logic        secondIrqReq,
    output logic             firstIrqLine,
    output logic             secondIrqLine,
    input  wire logic        uartTxd,
    input  wire logic        uartTxActive,
    output logic             uartRxd,
    input  wire logic        irRxPin,
    output logic             irTxPin,
    output logic             musicLinkFirst,
    output logic             musicLinkSecond,
    output logic             highSpeedEnable,
    output logic             halfDuplex,
    output logic      [2:0]  irModeSel,
    output logic             irq
);
    import spc_pkg::*;

    logic [7:0]  firstMode_reg;
    logic [7:0]  firstMode_next;
    logic [7:0]  secondMode_reg;
    logic [7:0]  secondMode_next;
    logic [7:0]  irOption_reg;
    logic [7:0]  irOption_next;
    logic [7:0]  irTimeout_reg;
    logic [7:0]  irTimeout_next;
    logic [3:0]  intStatus_reg;
    logic [3:0]  intStatus_next;
    logic [3:0]  intMask_reg;
    logic [3:0]  intMask_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        firstLine_reg;
    logic        firstLine_next;
    logic        secondLine_reg;
    logic        secondLine_next;
    logic        uartRxd_reg;
    logic        uartRxd_next;
    logic        irTx_reg;
    logic        irTx_next;
    logic        irq_reg;
    logic        irq_next;
    logic        firstReqDly_reg;
    logic        secondReqDly_reg;

    logic [11:0] regIdx;
    logic        setupPhase;
    logic        writeTake;
    logic        hit;
    logic [7:0]  readByte;
    logic        blanking;
    logic        blankEnd;
    logic        rxLevel;
    logic [3:0]  events;
    logic        shareIrq;

    assign shareIrq = firstMode_reg[SHARE_IRQ_BIT];

    spc_blank_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) spc_blank_timer_inst (
        .mclk     (mclk),
        .rst      (rst),
        .active   (uartTxActive),
        .steps    (irTimeout_reg),
        .blanking (blanking),
        .blankEnd (blankEnd)
    );

    // apb decode: word index from the byte address, no wait states
    always_comb
    begin
        regIdx = paddr[13:2];
        setupPhase = psel && !penable;
        writeTake = psel && penable && pwrite && pready_reg;
        hit = 1'b1;
        readByte = 8'h00;
        unique case (regIdx)
            FIRST_PORT_BASE_IDX + MODE_IDX:
            begin
                readByte = firstMode_reg;
            end
            SECOND_PORT_BASE_IDX + MODE_IDX:
            begin
                readByte = secondMode_reg;
            end
            SECOND_PORT_BASE_IDX + IR_OPTION_IDX:
            begin
                readByte = irOption_reg;
            end
            SECOND_PORT_BASE_IDX + IR_TIMEOUT_IDX:
            begin
                readByte = irTimeout_reg;
            end
            INT_STATUS_IDX:
            begin
                readByte = {4'h0, intStatus_reg};
            end
            INT_MASK_IDX:
            begin
                readByte = {4'h0, intMask_reg};
            end
            LINK_STATE_IDX:
            begin
                readByte = {4'h0, rxLevel, blanking, secondLine_reg, firstLine_reg};
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        pready_next = setupPhase;
        pslverr_next = setupPhase && !hit;
        prdata_next = (setupPhase && hit && !pwrite) ? {24'h000000, readByte} : 32'h00000000;
    end

    // register writes, reserved bits are kept at zero
    always_comb
    begin
        firstMode_next = firstMode_reg;
        secondMode_next = secondMode_reg;
        irOption_next = irOption_reg;
        irTimeout_next = irTimeout_reg;
        intMask_next = intMask_reg;
        if (writeTake && !pslverr_reg)
        begin
            if (regIdx == FIRST_PORT_BASE_IDX + MODE_IDX)
            begin
                firstMode_next = pwdata[7:0] & FIRST_MODE_WMASK;
            end
            if (regIdx == SECOND_PORT_BASE_IDX + MODE_IDX)
            begin
                secondMode_next = pwdata[7:0] & SECOND_MODE_WMASK;
            end
            if (regIdx == SECOND_PORT_BASE_IDX + IR_OPTION_IDX)
            begin
                irOption_next = pwdata[7:0] & IR_OPTION_WMASK;
            end
            if (regIdx == SECOND_PORT_BASE_IDX + IR_TIMEOUT_IDX)
            begin
                irTimeout_next = pwdata[7:0];
            end
            if (regIdx == INT_MASK_IDX)
            begin
                intMask_next = pwdata[3:0] & INT_WMASK;
            end
        end
    end

    // interrupt sharing and infrared line conditioning
    always_comb
    begin
        // shared mode wires both requests to both lines, harmless when one is unrouted
        firstLine_next = firstIrqReq || (shareIrq && secondIrqReq);
        secondLine_next = secondIrqReq || (shareIrq && firstIrqReq);
        rxLevel = irRxPin ^ irOption_reg[RX_POL_BIT];
        // blanked receive idles high so the uart sees no start bit
        uartRxd_next = (irOption_reg[DUPLEX_BIT] && blanking) ? 1'b1 : rxLevel;
        irTx_next = uartTxd ^ irOption_reg[TX_POL_BIT];
        events = 4'h0;
        events[EV_FIRST_IRQ] = firstIrqReq && !firstReqDly_reg;
        events[EV_SECOND_IRQ] = secondIrqReq && !secondReqDly_reg;
        events[EV_BLANK_END] = blankEnd && irOption_reg[DUPLEX_BIT];
        events[EV_RX_DROP] = irOption_reg[DUPLEX_BIT] && blanking && !rxLevel;
        intStatus_next = intStatus_reg;
        if (writeTake && !pslverr_reg && regIdx == INT_STATUS_IDX)
        begin
            intStatus_next = intStatus_reg & ~pwdata[3:0];
        end
        // a new event wins over a clear in the same cycle
        intStatus_next = intStatus_next | events;
        irq_next = |(intStatus_next & intMask_reg);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            firstMode_reg <= FIRST_MODE_RESET;
            secondMode_reg <= SECOND_MODE_RESET;
            irOption_reg <= IR_OPTION_RESET;
            irTimeout_reg <= IR_TIMEOUT_RESET;
            intStatus_reg <= 4'h0;
            intMask_reg <= INT_MASK_RESET;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            firstLine_reg <= 1'b0;
            secondLine_reg <= 1'b0;
            uartRxd_reg <= 1'b1;
            irTx_reg <= 1'b0;
            irq_reg <= 1'b0;
            firstReqDly_reg <= 1'b0;
            secondReqDly_reg <= 1'b0;
        end
        else
        begin
            firstMode_reg <= firstMode_next;
            secondMode_reg <= secondMode_next;
            irOption_reg <= irOption_next;
            irTimeout_reg <= irTimeout_next;
            intStatus_reg <= intStatus_next;
            intMask_reg <= intMask_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            firstLine_reg <= firstLine_next;
            secondLine_reg <= secondLine_next;
            uartRxd_reg <= uartRxd_next;
            irTx_reg <= irTx_next;
            irq_reg <= irq_next;
            firstReqDly_reg <= firstIrqReq;
            secondReqDly_reg <= secondIrqReq;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign firstIrqLine = firstLine_reg;
    assign secondIrqLine = secondLine_reg;
    assign uartRxd = uartRxd_reg;
    assign irTxPin = irTx_reg;
    assign musicLinkFirst = firstMode_reg[MUSIC_LINK_BIT];
    assign musicLinkSecond = secondMode_reg[MUSIC_LINK_BIT];
    assign highSpeedEnable = secondMode_reg[HIGH_SPEED_BIT];
    assign halfDuplex = irOption_reg[DUPLEX_BIT];
    assign irModeSel = irOption_reg[IR_MODE_MSB:IR_MODE_LSB];
    assign irq = irq_reg;
endmodule // spc_serial_cfg
`default_nettype wire

/* File: dv/spc_serial_cfg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module spc_serial_cfg_monitor #(
    parameter logic [15:0] STEP_CYCLES = 16'd8
)
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        firstIrqReq,
    input wire logic        secondIrqReq,
    input wire logic        firstIrqLine,
    input wire logic        secondIrqLine,
    input wire logic        uartTxd,
    input wire logic        uartTxActive,
    input wire logic        uartRxd,
    input wire logic        irRxPin,
    input wire logic        irTxPin,
    input wire logic        musicLinkFirst,
    input wire logic        musicLinkSecond,
    input wire logic        highSpeedEnable,
    input wire logic        halfDuplex,
    input wire logic [2:0]  irModeSel,
    input wire logic        irq
);
    // shadow copies rebuilt from completed writes
    logic [7:0] fmSh;
    logic [7:0] smSh;
    logic [5:0] optSh;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fmSh <= 8'h00;
            smSh <= 8'h00;
            optSh <= 6'h02;
        end
        else if (psel && penable && pready && pwrite)
        begin
            if (paddr == 14'h03c0) fmSh <= pwdata[7:0] & 8'h81;
            if (paddr == 14'h07c0) smSh <= pwdata[7:0] & 8'h03;
            if (paddr == 14'h07c4) optSh <= pwdata[5:0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
    a_slverr_unmapped: assert property (pready |-> pslverr == !(paddr inside {14'h03c0, 14'h07c0, 14'h07c4,
        14'h07c8, 14'h0800, 14'h0804, 14'h0808})) else $error("error flag wrong");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    a_share_first: assert property (!$past(rst) |-> firstIrqLine == ($past(firstIrqReq) ||
        ($past(fmSh[7]) && $past(secondIrqReq)))) else $error("first line wrong");
    a_share_second: assert property (!$past(rst) |-> secondIrqLine == ($past(secondIrqReq) ||
        ($past(fmSh[7]) && $past(firstIrqReq)))) else $error("second line wrong");
    a_tx_polarity: assert property (!$past(rst) |-> irTxPin == ($past(uartTxd) ^ $past(optSh[1])))
        else $error("transmit polarity wrong");
    a_rx_polarity: assert property (!$past(rst) && !$past(halfDuplex) |->
        uartRxd == ($past(irRxPin) ^ $past(optSh[0]))) else $error("receive polarity wrong");
    a_field_map: assert property ({musicLinkFirst, musicLinkSecond, highSpeedEnable, halfDuplex, irModeSel} ==
        {fmSh[0], smSh[0], smSh[1], optSh[2], optSh[5:3]}) else $error("field outputs wrong");
    a_blank_tx: assert property ($past(uartTxActive) && uartTxActive && halfDuplex && $past(halfDuplex)
        |=> uartRxd) else $error("receive not blanked");
endmodule // spc_serial_cfg_monitor
`default_nettype wire

/* File: dv/tb_spc_serial_cfg.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_spc_serial_cfg;
    import spc_pkg::*;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0;
    logic firstIrqReq = 0, secondIrqReq = 0, uartTxd = 0, uartTxActive = 0, irRxPin = 0;
    logic [31:0] prdata;
    logic pready, pslverr, firstIrqLine, secondIrqLine, uartRxd, irTxPin, irq;
    logic musicLinkFirst, musicLinkSecond, highSpeedEnable, halfDuplex;
    logic [2:0] irModeSel;
    int n_fail = 0;
    int n_checks = 0;
    logic [31:0] expQ[$];
    logic [13:0] cfgAddr[4] = '{14'h03c0, 14'h07c0, 14'h07c4, 14'h07c8};
    logic [31:0] cfgDef[4] = '{32'h0, 32'h0, 32'h2, 32'h3};
    logic [31:0] cfgMask[4] = '{32'h81, 32'h3, 32'h3f, 32'hff};
    spc_serial_cfg #(.STEP_CYCLES(16'd8)) spc_serial_cfg_inst (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .firstIrqReq(firstIrqReq), .secondIrqReq(secondIrqReq), .firstIrqLine(firstIrqLine),
        .secondIrqLine(secondIrqLine), .uartTxd(uartTxd), .uartTxActive(uartTxActive), .uartRxd(uartRxd),
        .irRxPin(irRxPin), .irTxPin(irTxPin), .musicLinkFirst(musicLinkFirst), .musicLinkSecond(musicLinkSecond),
        .highSpeedEnable(highSpeedEnable), .halfDuplex(halfDuplex), .irModeSel(irModeSel), .irq(irq));
    initial forever #2.5 mclk = ~mclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        // a read that never completed leaves its note behind
        if (expQ.size() != 0)
            n_fail++;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic rd(input logic [13:0] a, input logic [31:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // result watcher, oldest expectation first
    always @(posedge mclk)
        if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
            chk(prdata, expQ.pop_front());
    task automatic defaults();
        foreach (cfgAddr[i]) rd(cfgAddr[i], cfgDef[i]);
        rd(14'h0800, 32'h0);
        rd(14'h0804, 32'h0);
    endtask
    initial
    begin
        void'($urandom(76151));
        tick(4);
        rst <= 1'b0;
        defaults();
        foreach (cfgAddr[i])
        begin
            apb(1'b1, cfgAddr[i], cfgMask[i]);
            rd(cfgAddr[i], cfgMask[i]);
        end
        rd(14'h000c, 32'h0);
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, 14'h07c4, 32'(m << 3));
            tick(1);
            chk(32'(irModeSel), 32'(m));
        end
        // interrupt: raise, mask, clear
        apb(1'b1, 14'h0800, 32'hf);
        apb(1'b1, 14'h0804, 32'h1);
        firstIrqReq <= 1'b1;
        tick(1);
        firstIrqReq <= 1'b0;
        secondIrqReq <= 1'b1;
        tick(1);
        secondIrqReq <= 1'b0;
        tick(3);
        chk(32'(irq), 32'h1);
        rd(14'h0800, 32'h3);
        apb(1'b1, 14'h0800, 32'h1);
        tick(2);
        chk(32'(irq), 32'h0);
        rd(14'h0800, 32'h2);
        // sharing from the second request, then the first request alone with sharing off
        apb(1'b1, 14'h03c0, 32'h80);
        secondIrqReq <= 1'b1;
        tick(3);
        chk(32'({firstIrqLine, secondIrqLine}), 32'h3);
        secondIrqReq <= 1'b0;
        apb(1'b1, 14'h03c0, 32'h0);
        firstIrqReq <= 1'b1;
        tick(3);
        chk(32'({firstIrqLine, secondIrqLine}), 32'h2);
        rd(14'h0808, 32'h1);
        firstIrqReq <= 1'b0;
        // random traffic, judged by the monitor
        repeat (4)
        begin
            apb(1'b1, 14'h07c4, $urandom & 32'h0f);
            apb(1'b1, 14'h03c0, $urandom & 32'h80);
            repeat (20)
            begin
                @(posedge mclk);
                uartTxd <= 1'($urandom);
                uartTxActive <= 1'($urandom);
                irRxPin <= 1'($urandom);
                firstIrqReq <= 1'($urandom);
                secondIrqReq <= 1'($urandom);
            end
        end
        tick(1);
        firstIrqReq <= 1'b0;
        secondIrqReq <= 1'b0;
        uartTxActive <= 1'b0;
        irRxPin <= 1'b0;
        // blanking, timeout two steps of eight cycles
        apb(1'b1, 14'h07c8, 32'h2);
        apb(1'b1, 14'h07c4, 32'h4);
        apb(1'b1, 14'h0800, 32'hf);
        uartTxActive <= 1'b1;
        tick(5);
        uartTxActive <= 1'b0;
        tick(17);
        chk(32'(uartRxd), 32'h1);
        tick(1);
        chk(32'(uartRxd), 32'h0);
        rd(14'h0800, 32'hc);
        apb(1'b1, 14'h07c8, 32'h0);
        uartTxActive <= 1'b1;
        tick(5);
        chk(32'(uartRxd), 32'h1);
        uartTxActive <= 1'b0;
        tick(6);
        chk(32'(uartRxd), 32'h0);
        apb(1'b1, 14'h0804, 32'hf);
        tick(2);
        chk(32'(irq), 32'h1);
        rst <= 1'b1;
        tick(4);
        rst <= 1'b0;
        defaults();
        chk(32'(irq), 32'h0);
        tick(2);
        conclude();
    end
endmodule // tb_spc_serial_cfg
bind spc_serial_cfg spc_serial_cfg_monitor #(.STEP_CYCLES(STEP_CYCLES)) spc_serial_cfg_monitor_inst (.mclk(mclk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .firstIrqReq(firstIrqReq), .secondIrqReq(secondIrqReq),
    .firstIrqLine(firstIrqLine), .secondIrqLine(secondIrqLine), .uartTxd(uartTxd), .uartTxActive(uartTxActive),
    .uartRxd(uartRxd), .irRxPin(irRxPin), .irTxPin(irTxPin), .musicLinkFirst(musicLinkFirst),
    .musicLinkSecond(musicLinkSecond), .highSpeedEnable(highSpeedEnable), .halfDuplex(halfDuplex),
    .irModeSel(irModeSel), .irq(irq));
`default_nettype wire
